// ### shared/rdcd_consts.svh
`ifndef RDCD_CONSTS_SVH
`define RDCD_CONSTS_SVH

// ****************************************
// Terminal and function codes
// ****************************************
`define RDCD_NUM_TERM      6
`define RDCD_FUNC_W        8
`define RDCD_FUNC_FWD      8'h00
`define RDCD_FUNC_REV      8'h01
`define RDCD_SRC_W         8
`define RDCD_SRC_TERMINAL  8'h01

// ****************************************
// Terminal positions and reset value
// ****************************************
`define RDCD_TERM_1        0
`define RDCD_TERM_2        1
`define RDCD_TERM_3        2
`define RDCD_TERM_4        3
`define RDCD_TERM_5        4
`define RDCD_TERM_6        5
`define RDCD_OUT_RST       1'h0

`endif

// ### shared/rdcd_pkg.sv
`default_nettype none
`include "rdcd_consts.svh"

package rdcd_pkg;

  typedef logic [`RDCD_FUNC_W-1:0] rdcd_func_t;
  typedef logic [`RDCD_SRC_W-1:0]  rdcd_src_t;

  typedef enum logic [1:0] {
    RDCD_DIR_STOP,
    RDCD_DIR_FWD,
    RDCD_DIR_REV
  } rdcd_mode_t;

endpackage

`default_nettype wire

// ### rtl/rdcd_term_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "rdcd_consts.svh"

module rdcd_term_decode (
  // Terminal
  input  wire logic              term_level,
  input  wire logic              term_nc,
  input  wire rdcd_pkg::rdcd_func_t func_sel,
  // Decoded commands
  output logic                   fwd_active,
  output logic                   rev_active
);
  import rdcd_pkg::*;

  logic level_eff;

  // Normally closed terminal reads open as asserted
  assign level_eff  = term_level ^ term_nc;
  assign fwd_active = level_eff & (func_sel == `RDCD_FUNC_FWD);
  assign rev_active = level_eff & (func_sel == `RDCD_FUNC_REV);

endmodule

`default_nettype wire

// ### rtl/rdcd_run_decode.sv
// Function
// - Forward run input high gives run forward, low gives stop.
// - Reverse run input high gives run reverse, low gives stop.
// - Forward and reverse active together give stop.
// - A normally closed terminal counts an open input as an active command.
// - Forward and reverse functions may be assigned to any of six terminals.
// - The keypad run direction setting does not affect the terminal commands.
// - Commands are levels, so a command already active after reset starts the motor.
`timescale 1ns/100ps
`default_nettype none
`include "rdcd_consts.svh"

module rdcd_run_decode (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Input terminals
  input  wire logic [`RDCD_NUM_TERM-1:0]   term_level,
  input  wire logic [`RDCD_NUM_TERM-1:0]   term_nc,
  // Configuration
  input  wire rdcd_pkg::rdcd_func_t        input_function_select_1,
  input  wire rdcd_pkg::rdcd_func_t        input_function_select_2,
  input  wire rdcd_pkg::rdcd_func_t        input_function_select_3,
  input  wire rdcd_pkg::rdcd_func_t        input_function_select_4,
  input  wire rdcd_pkg::rdcd_func_t        input_function_select_5,
  input  wire rdcd_pkg::rdcd_func_t        input_function_select_6,
  input  wire rdcd_pkg::rdcd_src_t         run_command_source_setting,
  input  wire logic                        keypad_run_direction_setting,
  // Status
  output logic                             run_mode,
  output logic                             dir_reverse,
  output logic                             forward_run_input,
  output logic                             reverse_run_input
);
  import rdcd_pkg::*;

  // ****************************************
  // Per-terminal decode
  // ****************************************

  logic [`RDCD_NUM_TERM-1:0] fwd_term;
  logic [`RDCD_NUM_TERM-1:0] rev_term;

  // Identical decoders, so either run function may sit on any terminal
  rdcd_term_decode u_dec_1 (
    .term_level (term_level[`RDCD_TERM_1]),
    .term_nc    (term_nc[`RDCD_TERM_1]),
    .func_sel   (input_function_select_1),
    .fwd_active (fwd_term[`RDCD_TERM_1]),
    .rev_active (rev_term[`RDCD_TERM_1])
  );

  rdcd_term_decode u_dec_2 (
    .term_level (term_level[`RDCD_TERM_2]),
    .term_nc    (term_nc[`RDCD_TERM_2]),
    .func_sel   (input_function_select_2),
    .fwd_active (fwd_term[`RDCD_TERM_2]),
    .rev_active (rev_term[`RDCD_TERM_2])
  );

  rdcd_term_decode u_dec_3 (
    .term_level (term_level[`RDCD_TERM_3]),
    .term_nc    (term_nc[`RDCD_TERM_3]),
    .func_sel   (input_function_select_3),
    .fwd_active (fwd_term[`RDCD_TERM_3]),
    .rev_active (rev_term[`RDCD_TERM_3])
  );

  rdcd_term_decode u_dec_4 (
    .term_level (term_level[`RDCD_TERM_4]),
    .term_nc    (term_nc[`RDCD_TERM_4]),
    .func_sel   (input_function_select_4),
    .fwd_active (fwd_term[`RDCD_TERM_4]),
    .rev_active (rev_term[`RDCD_TERM_4])
  );

  rdcd_term_decode u_dec_5 (
    .term_level (term_level[`RDCD_TERM_5]),
    .term_nc    (term_nc[`RDCD_TERM_5]),
    .func_sel   (input_function_select_5),
    .fwd_active (fwd_term[`RDCD_TERM_5]),
    .rev_active (rev_term[`RDCD_TERM_5])
  );

  rdcd_term_decode u_dec_6 (
    .term_level (term_level[`RDCD_TERM_6]),
    .term_nc    (term_nc[`RDCD_TERM_6]),
    .func_sel   (input_function_select_6),
    .fwd_active (fwd_term[`RDCD_TERM_6]),
    .rev_active (rev_term[`RDCD_TERM_6])
  );

  // ****************************************
  // Function merge
  // ****************************************

  logic fwd_any;
  logic rev_any;

  // Several terminals on one function are ORed
  assign fwd_any = |fwd_term;
  assign rev_any = |rev_term;

  // ****************************************
  // Source and keypad settings
  // ****************************************

  logic src_term;
  logic keypad_unused;

  // Any other source code leaves the terminals without effect on run_mode and dir_reverse
  assign src_term = (run_command_source_setting == `RDCD_SRC_TERMINAL);
  // Keypad routing only matters for the keypad key, never here
  assign keypad_unused = keypad_run_direction_setting;

  // ****************************************
  // Command classification
  // ****************************************

  logic cmd_fwd_only;
  logic cmd_rev_only;
  logic cmd_conflict;
  logic cmd_idle;

  assign cmd_fwd_only = fwd_any & ~rev_any;
  assign cmd_rev_only = rev_any & ~fwd_any;
  // Both at once stops rather than picking a winner, so a miswired pair fails safe
  assign cmd_conflict = fwd_any & rev_any;
  assign cmd_idle     = ~fwd_any & ~rev_any;

  // ****************************************
  // Mode resolution
  // ****************************************

  rdcd_mode_t mode_nxt;

  always_comb begin
    mode_nxt = RDCD_DIR_STOP;
    if (src_term) begin
      if (cmd_conflict) begin
        mode_nxt = RDCD_DIR_STOP;
      end else if (cmd_fwd_only) begin
        mode_nxt = RDCD_DIR_FWD;
      end else if (cmd_rev_only) begin
        mode_nxt = RDCD_DIR_REV;
      end else if (cmd_idle) begin
        mode_nxt = RDCD_DIR_STOP;
      end
    end
  end

  // ****************************************
  // Next values
  // ****************************************

  logic run_mode_nxt;
  logic dir_reverse_nxt;
  logic fwd_status_nxt;
  logic rev_status_nxt;

  assign run_mode_nxt    = (mode_nxt != RDCD_DIR_STOP);
  assign dir_reverse_nxt = (mode_nxt == RDCD_DIR_REV);
  // Status follows the terminals whatever the source, for monitoring
  assign fwd_status_nxt  = fwd_any;
  assign rev_status_nxt  = rev_any;

  // ****************************************
  // Registers
  // ****************************************

  logic run_mode_r;
  logic dir_reverse_r;
  logic fwd_status_r;
  logic rev_status_r;

  // No start latch: a command held through reset runs on the first edge after it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_mode_r <= `RDCD_OUT_RST;
    end else begin
      run_mode_r <= run_mode_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dir_reverse_r <= `RDCD_OUT_RST;
    end else begin
      dir_reverse_r <= dir_reverse_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fwd_status_r <= `RDCD_OUT_RST;
    end else begin
      fwd_status_r <= fwd_status_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rev_status_r <= `RDCD_OUT_RST;
    end else begin
      rev_status_r <= rev_status_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Straight from the flops, so no decode glitch reaches the pins
  assign run_mode          = run_mode_r;
  assign dir_reverse       = dir_reverse_r;
  assign forward_run_input = fwd_status_r;
  assign reverse_run_input = rev_status_r;

endmodule

`default_nettype wire

// ### verif/rdcd_field_sw.sv
`timescale 1ns/100ps
`default_nettype none
module rdcd_field_sw (
  input  wire logic       ref_clk,
  input  wire logic [5:0] closed,
  output logic      [5:0] term_level
);
  // Contacts settle just after an edge
  initial term_level = 6'h00;
  always @(posedge ref_clk) term_level <= closed;
endmodule
`default_nettype wire

// ### verif/rdcd_chk_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rdcd_chk import rdcd_pkg::*; (
  input wire logic       ref_clk, rst_n, run_mode, dir_reverse, forward_run_input, reverse_run_input,
  input wire logic [5:0] term_level, term_nc,
  input wire rdcd_func_t input_function_select_1, input_function_select_2, input_function_select_3,
  input wire rdcd_func_t input_function_select_4, input_function_select_5, input_function_select_6,
  input wire rdcd_src_t  run_command_source_setting
);
  rdcd_func_t s [6];
  logic       f, r, t;
  assign s = '{input_function_select_1, input_function_select_2, input_function_select_3,
               input_function_select_4, input_function_select_5, input_function_select_6};
  assign t = run_command_source_setting == 8'h01;
  always_comb begin
    f = 1'h0;
    r = 1'h0;
    for (int i = 0; i < 6; i++) begin
      f |= (term_level[i] ^ term_nc[i]) && s[i] == 8'h00;
      r |= (term_level[i] ^ term_nc[i]) && s[i] == 8'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  fwd_status_a: assert property (rst_n |=> forward_run_input == $past(f)) else $error("fwd status");
  rev_status_a: assert property (rst_n |=> reverse_run_input == $past(r)) else $error("rev status");
  fwd_run_a: assert property (rst_n && t && f && !r |=> run_mode && !dir_reverse) else $error("fwd run");
  rev_run_a: assert property (rst_n && t && r && !f |=> run_mode && dir_reverse) else $error("rev run");
  both_stop_a: assert property (rst_n && f && r |=> !run_mode && !dir_reverse) else $error("conflict");
  source_gate_a: assert property (rst_n && !t |=> !run_mode && !dir_reverse) else $error("source");
  idle_stop_a: assert property (rst_n && !f && !r |=> !run_mode) else $error("idle");
  stop_dir_a: assert property (!run_mode |-> !dir_reverse) else $error("stop dir");
  power_up_run_a: assert property ($rose(rst_n) && t && f && !r |=> run_mode && !dir_reverse) else $error("power up");
  cover property (t && f && !r);
  cover property (t && r && !f);
  cover property (f && r);
  cover property ($rose(rst_n) && t && f);
endmodule
bind rdcd_run_decode rdcd_chk u_chk (
  .ref_clk                    (ref_clk),
  .rst_n                      (rst_n),
  .run_mode                   (run_mode),
  .dir_reverse                (dir_reverse),
  .forward_run_input          (forward_run_input),
  .reverse_run_input          (reverse_run_input),
  .term_level                 (term_level),
  .term_nc                    (term_nc),
  .input_function_select_1    (input_function_select_1),
  .input_function_select_2    (input_function_select_2),
  .input_function_select_3    (input_function_select_3),
  .input_function_select_4    (input_function_select_4),
  .input_function_select_5    (input_function_select_5),
  .input_function_select_6    (input_function_select_6),
  .run_command_source_setting (run_command_source_setting)
);
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rdcd_pkg::*;
  logic       ref_clk = 0, rst_n = 0, kp = 0, run, rev, fst, rst;
  logic [5:0] closed = 6'h01, nc = 6'h00, lvl;
  rdcd_func_t fs [6] = '{default: 8'h00};
  rdcd_src_t  src = 8'h01;
  int         fails = 0, checked = 0, seed = 75, f, r, t, g;
  int         exp_q [$];
  always #2 ref_clk = ~ref_clk;
  rdcd_field_sw u_sw (.ref_clk(ref_clk), .closed(closed), .term_level(lvl));
  rdcd_run_decode u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .term_level(lvl), .term_nc(nc),
    .input_function_select_1(fs[0]), .input_function_select_2(fs[1]), .input_function_select_3(fs[2]),
    .input_function_select_4(fs[3]), .input_function_select_5(fs[4]), .input_function_select_6(fs[5]),
    .run_command_source_setting(src), .keypad_run_direction_setting(kp), .run_mode(run),
    .dir_reverse(rev), .forward_run_input(fst), .reverse_run_input(rst));
  task check(input logic a, input logic b);
    checked++;
    if (a !== b) begin
      fails++;
      $display("MISMATCH at %0t: got %b want %b", $time, a, b);
    end
  endtask
  task conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    // Forward held through reset must start the motor
    rst_n <= 1;
    for (int n = 0; n < 500; n++) begin
      @(posedge ref_clk);
      f = 0;
      r = 0;
      for (int i = 0; i < 6; i++) if (lvl[i] ^ nc[i]) begin
        if (fs[i] == 8'h00) f = 1;
        if (fs[i] == 8'h01) r = 1;
      end
      t = src == 8'h01;
      g = rst_n;
      exp_q.push_back(g && f);
      exp_q.push_back(g && r);
      exp_q.push_back(g && t && (f != r));
      exp_q.push_back(g && t && r && !f);
      // Mid-run reset with random commands still changing every cycle through it
      rst_n <= (n < 250 || n > 253);
      if (n > 0) begin
        closed <= 6'($random(seed));
        nc <= ($random(seed) & 3) ? 6'h00 : 6'(($random(seed)));
        for (int i = 0; i < 6; i++) fs[i] <= 8'($unsigned($random(seed)) % 3);
        src <= ($random(seed) & 7) ? 8'h01 : 8'($random(seed));
        kp <= 1'($random(seed));
      end
      @(negedge ref_clk);
      check(fst, 1'(exp_q.pop_front()));
      check(rst, 1'(exp_q.pop_front()));
      check(run, 1'(exp_q.pop_front()));
      check(rev, 1'(exp_q.pop_front()));
    end
    conclude;
  end
endmodule
`default_nettype wire
